// File: core/icir_regs.sv
// Isochronous context interrupt event and mask registers with an Avalon-MM slave port.
//
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module icir_regs
   import icir_pkg::*;
(
   // Clock and reset.
   input  wire logic                 clk,
   input  wire logic                 nrst,
   // Avalon-MM slave.
   input  wire logic [ICIR_AW-1:0]   avs_address,
   input  wire logic                 avs_read,
   input  wire logic                 avs_write,
   input  wire logic [ICIR_DW-1:0]   avs_writedata,
   input  wire logic [ICIR_BEW-1:0]  avs_byteenable,
   output logic      [ICIR_DW-1:0]   avs_readdata,
   output logic                      avs_waitrequest,
   // Context interrupt signals from the DMA engines.
   input  wire logic [ICIR_TX_N-1:0] tx_context_int,
   input  wire logic [ICIR_RX_N-1:0] rx_channel_int,
   // Summary event bits and interrupt.
   output logic                      summary_transmit_event,
   output logic                      summary_receive_event,
   output logic                      irq
);

   // Bus state.
   logic                 waitrequest_ff;
   logic [ICIR_DW-1:0]   readdata_ff;
   logic                 rd_acc;
   logic                 wr_acc;
   logic [ICIR_DW-1:0]   wd;
   logic [ICIR_DW-1:0]   rd_val;

   // Register contents.
   logic [ICIR_TX_N-1:0] tx_ev;
   logic [ICIR_TX_N-1:0] tx_mask;
   logic [ICIR_RX_N-1:0] rx_ev;
   logic [ICIR_RX_N-1:0] rx_mask;
   logic [ICIR_TX_N-1:0] tx_rise;
   logic [ICIR_RX_N-1:0] rx_rise;

   // Software strobes.
   logic [ICIR_TX_N-1:0] tx_ev_set;
   logic [ICIR_TX_N-1:0] tx_ev_clr;
   logic [ICIR_TX_N-1:0] tx_msk_set;
   logic [ICIR_TX_N-1:0] tx_msk_clr;
   logic [ICIR_RX_N-1:0] rx_ev_set;
   logic [ICIR_RX_N-1:0] rx_ev_clr;
   logic [ICIR_RX_N-1:0] rx_msk_set;
   logic [ICIR_RX_N-1:0] rx_msk_clr;

   // Summary, control and interrupt state; index 0 is transmit, index 1 is receive.
   logic                 sum_tx_ff;
   logic                 sum_rx_ff;
   logic                 gie_ff;
   logic [1:0]           main_msk_ff;
   logic [1:0]           irq_stat_ff;
   logic [1:0]           irq_msk_ff;
   logic [1:0]           stat_set;
   logic [1:0]           stat_clr;
   logic                 irq_ff;

   // The slave answers one cycle after a request; accepts happen with waitrequest low.
   assign rd_acc = avs_read & ~waitrequest_ff;
   assign wr_acc = avs_write & ~waitrequest_ff;
   assign wd     = icir_be_mask(avs_writedata, avs_byteenable);

   // Completion edges of each transmit context and receive channel.
   icir_rise_det #(.W(ICIR_TX_N)) u_tx_rise (
      .clk   (clk),
      .nrst  (nrst),
      .level (tx_context_int),
      .rise  (tx_rise)
   );

   icir_rise_det #(.W(ICIR_RX_N)) u_rx_rise (
      .clk   (clk),
      .nrst  (nrst),
      .level (rx_channel_int),
      .rise  (rx_rise)
   );

   // Write strobes; a write at a set or clear address touches only the 1 bits written.
   assign tx_ev_set  = (wr_acc && avs_address == ICIR_TX_EV_SET)  ? ICIR_TX_N'(wd) : '0;
   assign tx_ev_clr  = (wr_acc && avs_address == ICIR_TX_EV_CLR)  ? ICIR_TX_N'(wd) : '0;
   assign tx_msk_set = (wr_acc && avs_address == ICIR_TX_MSK_SET) ? ICIR_TX_N'(wd) : '0;
   assign tx_msk_clr = (wr_acc && avs_address == ICIR_TX_MSK_CLR) ? ICIR_TX_N'(wd) : '0;
   assign rx_ev_set  = (wr_acc && avs_address == ICIR_RX_EV_SET)  ? ICIR_RX_N'(wd) : '0;
   assign rx_ev_clr  = (wr_acc && avs_address == ICIR_RX_EV_CLR)  ? ICIR_RX_N'(wd) : '0;
   assign rx_msk_set = (wr_acc && avs_address == ICIR_RX_MSK_SET) ? ICIR_RX_N'(wd) : '0;
   assign rx_msk_clr = (wr_acc && avs_address == ICIR_RX_MSK_CLR) ? ICIR_RX_N'(wd) : '0;

   // Transmit events: context edges set them, only the clear address clears them.
   icir_rsc_reg #(.W(ICIR_TX_N), .RST(ICIR_TX_RST)) u_tx_ev (
      .clk    (clk),
      .nrst   (nrst),
      .hw_set (tx_rise),
      .sw_set (tx_ev_set),
      .sw_clr (tx_ev_clr),
      .bits   (tx_ev)
   );

   // Transmit mask, bit for bit aligned with the transmit events.
   icir_rsc_reg #(.W(ICIR_TX_N), .RST(ICIR_TX_RST)) u_tx_mask (
      .clk    (clk),
      .nrst   (nrst),
      .hw_set ('0),
      .sw_set (tx_msk_set),
      .sw_clr (tx_msk_clr),
      .bits   (tx_mask)
   );

   // Receive events, set by any input completion edge.
   icir_rsc_reg #(.W(ICIR_RX_N), .RST(ICIR_RX_RST)) u_rx_ev (
      .clk    (clk),
      .nrst   (nrst),
      .hw_set (rx_rise),
      .sw_set (rx_ev_set),
      .sw_clr (rx_ev_clr),
      .bits   (rx_ev)
   );

   // Receive mask.
   icir_rsc_reg #(.W(ICIR_RX_N), .RST(ICIR_RX_RST)) u_rx_mask (
      .clk    (clk),
      .nrst   (nrst),
      .hw_set ('0),
      .sw_set (rx_msk_set),
      .sw_clr (rx_msk_clr),
      .bits   (rx_mask)
   );

   // Read multiplexer; upper bits of every narrow register come back as zero.
   always_comb begin
      rd_val = ICIR_ZERO;
      unique case (avs_address)
         ICIR_TX_EV_SET:  rd_val[ICIR_TX_N-1:0] = tx_ev;
         ICIR_TX_EV_CLR:  rd_val[ICIR_TX_N-1:0] = tx_ev & tx_mask;
         ICIR_TX_MSK_SET: rd_val[ICIR_TX_N-1:0] = tx_mask;
         ICIR_TX_MSK_CLR: rd_val[ICIR_TX_N-1:0] = tx_mask;
         ICIR_RX_EV_SET:  rd_val[ICIR_RX_N-1:0] = rx_ev;
         ICIR_RX_EV_CLR:  rd_val[ICIR_RX_N-1:0] = rx_ev & rx_mask;
         ICIR_RX_MSK_SET: rd_val[ICIR_RX_N-1:0] = rx_mask;
         ICIR_RX_MSK_CLR: rd_val[ICIR_RX_N-1:0] = rx_mask;
         ICIR_CTRL: begin
            rd_val = icir_place_sum(main_msk_ff[0], main_msk_ff[1]);
            rd_val[ICIR_GIE_BIT] = gie_ff;
         end
         ICIR_IRQ_STAT:   rd_val = icir_place_sum(irq_stat_ff[0], irq_stat_ff[1]);
         ICIR_IRQ_MASK:   rd_val = icir_place_sum(irq_msk_ff[0], irq_msk_ff[1]);
         ICIR_SUMMARY:    rd_val = icir_place_sum(sum_tx_ff, sum_rx_ff);
         default:         rd_val = ICIR_ZERO;
      endcase
   end

   // Waitrequest drops for exactly one cycle per request, so every access takes two cycles.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         waitrequest_ff <= 1'b1;
      end else begin
         waitrequest_ff <= !((avs_read || avs_write) && waitrequest_ff);
      end
   end

   // Read data is captured with the answer to a read and held until the next read answer.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         readdata_ff <= ICIR_ZERO;
      end else if (avs_read && waitrequest_ff) begin
         readdata_ff <= rd_val;
      end
   end

   // Summary bits: any enabled context raises its summary event.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         sum_tx_ff <= 1'b0;
         sum_rx_ff <= 1'b0;
      end else begin
         sum_tx_ff <= |(tx_ev & tx_mask);
         sum_rx_ff <= |(rx_ev & rx_mask);
      end
   end

   // Control word: global enable and the main mask bits for both summaries.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         gie_ff      <= 1'b0;
         main_msk_ff <= 2'h0;
      end else if (wr_acc && avs_address == ICIR_CTRL) begin
         gie_ff      <= wd[ICIR_GIE_BIT];
         main_msk_ff <= {wd[ICIR_SUM_RX_BIT], wd[ICIR_SUM_TX_BIT]};
      end
   end

   // Interrupt mask word.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         irq_msk_ff <= 2'h0;
      end else if (wr_acc && avs_address == ICIR_IRQ_MASK) begin
         irq_msk_ff <= {wd[ICIR_SUM_RX_BIT], wd[ICIR_SUM_TX_BIT]};
      end
   end

   // A summary counts only while its main mask bit is 1.
   assign stat_set = {sum_rx_ff & main_msk_ff[1], sum_tx_ff & main_msk_ff[0]};

   // Read-clear removes only bits that the answer actually carried, so a late set survives.
   assign stat_clr = (rd_acc && avs_address == ICIR_IRQ_STAT) ?
                     {readdata_ff[ICIR_SUM_RX_BIT], readdata_ff[ICIR_SUM_TX_BIT]} : 2'h0;

   // Sticky status with set winning over the read clear.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         irq_stat_ff <= 2'h0;
      end else begin
         irq_stat_ff <= (irq_stat_ff & ~stat_clr) | stat_set;
      end
   end

   // Interrupt level, gated by the global enable whatever the masks say.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= gie_ff && |(irq_stat_ff & irq_msk_ff);
      end
   end

   // Outputs are the flip-flops themselves.
   assign avs_waitrequest        = waitrequest_ff;
   assign avs_readdata           = readdata_ff;
   assign summary_transmit_event = sum_tx_ff;
   assign summary_receive_event  = sum_rx_ff;
   assign irq                    = irq_ff;

   // Checks run on the one clock and rest during reset.
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   // A context edge is visible in its event bit one cycle later.
   AST_TX_EDGE_SETS: assert property (
      |tx_rise |=> ((tx_ev & $past(tx_rise)) == $past(tx_rise)))
      else $error("transmit edge did not set its event bit");

   AST_RX_EDGE_SETS: assert property (
      |rx_rise |=> ((rx_ev & $past(rx_rise)) == $past(rx_rise)))
      else $error("receive edge did not set its event bit");

   // Writing 1s at the set address sets those bits.
   AST_TX_SW_SET: assert property (
      (wr_acc && avs_address == ICIR_TX_EV_SET) |=> ((tx_ev & $past(wd[7:0])) == $past(wd[7:0])))
      else $error("set write did not set transmit event bits");

   // Event bits fall only after a write at the clear address.
   AST_TX_ONLY_CLR: assert property (
      (|($past(tx_ev) & ~tx_ev)) |-> $past(wr_acc && avs_address == ICIR_TX_EV_CLR))
      else $error("transmit event bit fell without a clear write");

   AST_RX_ONLY_CLR: assert property (
      (|($past(rx_ev) & ~rx_ev)) |-> $past(wr_acc && avs_address == ICIR_RX_EV_CLR))
      else $error("receive event bit fell without a clear write");

   // The clear address reads events ANDed with the mask, with zero above.
   AST_TX_CLR_READ: assert property (
      (avs_read && waitrequest_ff && avs_address == ICIR_TX_EV_CLR)
      |=> (readdata_ff == {24'h00_0000, $past(tx_ev & tx_mask)}))
      else $error("transmit clear read returned wrong data");

   AST_RX_CLR_READ: assert property (
      (avs_read && waitrequest_ff && avs_address == ICIR_RX_EV_CLR)
      |=> (readdata_ff == {28'h000_0000, $past(rx_ev & rx_mask)}))
      else $error("receive clear read returned wrong data");

   // Transmit mask reads return the mask at both addresses.
   AST_TX_MASK_READ: assert property (
      (avs_read && waitrequest_ff &&
       (avs_address == ICIR_TX_MSK_SET || avs_address == ICIR_TX_MSK_CLR))
      |=> (readdata_ff == {24'h00_0000, $past(tx_mask)}))
      else $error("transmit mask read returned wrong data");

   // Summary bits follow the masked events by one cycle.
   AST_SUMMARY: assert property (
      ##1 (sum_tx_ff == $past(|(tx_ev & tx_mask))) && (sum_rx_ff == $past(|(rx_ev & rx_mask))))
      else $error("summary bits disagree with masked events");

   // No interrupt once the global enable has been off for two cycles.
   AST_GIE_GATES: assert property (
      !gie_ff [*2] |-> !irq_ff)
      else $error("interrupt driven with global enable off");

   // A status bit needs its summary and main mask bit.
   AST_MAIN_MASK: assert property (
      $rose(irq_stat_ff[0]) |-> $past(sum_tx_ff && main_msk_ff[0]))
      else $error("transmit status set without summary and main mask");

   // Every request is answered on the following cycle.
   AST_ONE_WAIT: assert property (
      ((avs_read || avs_write) && waitrequest_ff) |=> !waitrequest_ff ##1 waitrequest_ff)
      else $error("waitrequest did not drop for exactly one cycle");

   // Receive set writes set their bits as well.
   AST_RX_SW_SET: assert property (
      (wr_acc && avs_address == ICIR_RX_EV_SET) |=> ((rx_ev & $past(wd[3:0])) == $past(wd[3:0])))
      else $error("set write did not set receive event bits");

   // A write at the set address never clears a bit.
   AST_TX_SET_KEEPS: assert property (
      (wr_acc && avs_address == ICIR_TX_EV_SET) |=> ((tx_ev & $past(tx_ev)) == $past(tx_ev)))
      else $error("set write cleared a transmit event bit");

   // The set address reads the raw events with zero above.
   AST_TX_SET_READ: assert property (
      (avs_read && waitrequest_ff && avs_address == ICIR_TX_EV_SET)
      |=> (readdata_ff == {24'h00_0000, $past(tx_ev)}))
      else $error("transmit set read returned wrong data");

   // Same for the receive events.
   AST_RX_SET_READ: assert property (
      (avs_read && waitrequest_ff && avs_address == ICIR_RX_EV_SET)
      |=> (readdata_ff == {28'h000_0000, $past(rx_ev)}))
      else $error("receive set read returned wrong data");

   // A mask bit falls only after a write at its clear address.
   AST_TX_MASK_CLR: assert property (
      (|($past(tx_mask) & ~tx_mask)) |-> $past(wr_acc && avs_address == ICIR_TX_MSK_CLR))
      else $error("transmit mask bit fell without a clear write");

   // The interrupt needs the global enable and an enabled status bit.
   AST_IRQ_CAUSE: assert property (
      irq_ff |-> $past(gie_ff && |(irq_stat_ff & irq_msk_ff)))
      else $error("interrupt driven without an enabled cause");

   // A status bit falls only after a read of the status word.
   AST_STAT_STICKY: assert property (
      (|($past(irq_stat_ff) & ~irq_stat_ff)) |-> $past(rd_acc && avs_address == ICIR_IRQ_STAT))
      else $error("status bit fell without a status read");

   // The receive status bit needs its summary and main mask bit.
   AST_RX_MAIN_MASK: assert property (
      $rose(irq_stat_ff[1]) |-> $past(sum_rx_ff && main_msk_ff[1]))
      else $error("receive status set without summary and main mask");

   // Main scenarios.
   COV_TX_IRQ: cover property ($rose(tx_context_int[0]) ##[1:20] irq_ff);
   COV_RX_CLR: cover property (rd_acc && avs_address == ICIR_RX_EV_CLR && |rx_ev);
   COV_SET_CLR_SAME: cover property (|(tx_rise & tx_ev_clr));

endmodule
`default_nettype wire

// File: core/icir_pkg.sv
// Constants, field layouts and helper functions for the isochronous context interrupt registers.
// Summary of operation
// - A transmit context completing a final-output command with interrupt bits set sets its bit.
// - A receive context completing any input command with interrupt bits set sets its bit.
// - An event bit is set by its signal's rising edge or a 1 written at set.
// - An event bit clears only by writing 1 at the clear address.
// - Transmit events sit at 90h set and 94h clear; 94h reads events AND mask.
// - Receive events sit at A0h set and A4h clear; A4h reads events AND mask.
// - Transmit event bits 7..0 name the context that raised summary transmit bit 6.
// - Transmit event bits 31..8 are reserved and always read zero.
// - Receive event bits 3..0 name the channel that raised summary receive bit 7.
// - Receive event bits 31..4 are reserved and always read zero.
// - After reset transmit event bits 31..8 are zero; low eight bits undefined.
// - Transmit mask sits at 98h set and 9Ch clear; both read the mask.
// - Each transmit mask bit aligns with its event bit; upper bits reset to zero.
// - The summary transmit interrupt fires only when its event and mask bit are both 1.
// - No interrupt is driven while the global interrupt enable is 0; here irq falls one cycle after the enable clears.
package icir_pkg;

   // Bus and field widths.
   localparam int ICIR_AW   = 8;
   localparam int ICIR_DW   = 32;
   localparam int ICIR_BEW  = 4;
   localparam int ICIR_TX_N = 8;
   localparam int ICIR_RX_N = 4;

   // Register byte offsets.
   localparam logic [ICIR_AW-1:0] ICIR_TX_EV_SET  = 8'h90;
   localparam logic [ICIR_AW-1:0] ICIR_TX_EV_CLR  = 8'h94;
   localparam logic [ICIR_AW-1:0] ICIR_TX_MSK_SET = 8'h98;
   localparam logic [ICIR_AW-1:0] ICIR_TX_MSK_CLR = 8'h9c;
   localparam logic [ICIR_AW-1:0] ICIR_RX_EV_SET  = 8'ha0;
   localparam logic [ICIR_AW-1:0] ICIR_RX_EV_CLR  = 8'ha4;
   localparam logic [ICIR_AW-1:0] ICIR_RX_MSK_SET = 8'ha8;
   localparam logic [ICIR_AW-1:0] ICIR_RX_MSK_CLR = 8'hac;
   localparam logic [ICIR_AW-1:0] ICIR_CTRL       = 8'hc0;
   localparam logic [ICIR_AW-1:0] ICIR_IRQ_STAT   = 8'hc4;
   localparam logic [ICIR_AW-1:0] ICIR_IRQ_MASK   = 8'hc8;
   localparam logic [ICIR_AW-1:0] ICIR_SUMMARY    = 8'hcc;

   // Field positions in the control, status, mask and summary words.
   localparam int ICIR_SUM_TX_BIT = 6;
   localparam int ICIR_SUM_RX_BIT = 7;
   localparam int ICIR_GIE_BIT    = 31;

   // Reset values.
   localparam logic [ICIR_TX_N-1:0] ICIR_TX_RST = 8'h00;
   localparam logic [ICIR_RX_N-1:0] ICIR_RX_RST = 4'h0;
   localparam logic [ICIR_DW-1:0]   ICIR_ZERO   = 32'h0000_0000;

   // Keeps only the byte lanes that the master enabled.
   function automatic logic [ICIR_DW-1:0] icir_be_mask(input logic [ICIR_DW-1:0] d,
                                                       input logic [ICIR_BEW-1:0] be);
      logic [ICIR_DW-1:0] m;
      m = ICIR_ZERO;
      for (int i = 0; i < ICIR_BEW; i++) begin
         m[i*8 +: 8] = be[i] ? d[i*8 +: 8] : 8'h00;
      end
      return m;
   endfunction

   // Places the transmit and receive summary fields into a word.
   function automatic logic [ICIR_DW-1:0] icir_place_sum(input logic tx, input logic rx);
      logic [ICIR_DW-1:0] w;
      w = ICIR_ZERO;
      w[ICIR_SUM_TX_BIT] = tx;
      w[ICIR_SUM_RX_BIT] = rx;
      return w;
   endfunction

endpackage

// File: core/icir_rise_det.sv
// Rising-edge detector for a vector of same-clock completion signals.
`timescale 1ns/1ns
`default_nettype none
module icir_rise_det #(
   parameter int W = 8
) (
   // Clock and reset.
   input  wire logic         clk,
   input  wire logic         nrst,
   // Level in, one-cycle pulse out.
   input  wire logic [W-1:0] level,
   output logic      [W-1:0] rise
);

   logic [W-1:0] prev_ff;

   // Previous level; cleared at reset so a level high at release counts as an edge.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         prev_ff <= '0;
      end else begin
         prev_ff <= level;
      end
   end

   // A bit rises when it is high now and was low one cycle ago.
   assign rise = level & ~prev_ff;

endmodule
`default_nettype wire

// File: core/icir_rsc_reg.sv
// Read/set/clear register bank in which a set always wins over a clear.
`timescale 1ns/1ns
`default_nettype none
module icir_rsc_reg #(
   parameter int           W   = 8,
   parameter logic [W-1:0] RST = '0
) (
   // Clock and reset.
   input  wire logic         clk,
   input  wire logic         nrst,
   // Set and clear strobes, one bit per position.
   input  wire logic [W-1:0] hw_set,
   input  wire logic [W-1:0] sw_set,
   input  wire logic [W-1:0] sw_clr,
   // Stored bits.
   output logic      [W-1:0] bits
);

   logic [W-1:0] bits_ff;
   logic [W-1:0] nxt_bits;

   // A clear only removes bits; any set in the same cycle keeps the bit, so no event is lost.
   assign nxt_bits = (bits_ff & ~sw_clr) | sw_set | hw_set;

   // Storage.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         bits_ff <= RST;
      end else begin
         bits_ff <= nxt_bits;
      end
   end

   assign bits = bits_ff;

endmodule
`default_nettype wire

// File: bench/tb_top.sv
// Self-checking testbench for the isochronous context interrupt registers.
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin \
   total_checks++; \
   if ((got) !== (exp)) begin \
      err_count++; \
      $display("unexpected at %0t: got %h expected %h", $time, (got), (exp)); \
   end \
end
module tb_top
   import icir_pkg::*;
   ;
   // Every mapped event and mask address, used for sweeps and random picks.
   localparam logic [ICIR_AW-1:0] ADDR_TAB [8] = '{ICIR_TX_EV_SET, ICIR_TX_EV_CLR,
      ICIR_TX_MSK_SET, ICIR_TX_MSK_CLR, ICIR_RX_EV_SET, ICIR_RX_EV_CLR, ICIR_RX_MSK_SET,
      ICIR_RX_MSK_CLR};
   logic                 clk;
   logic                 nrst;
   logic [ICIR_AW-1:0]   avs_address;
   logic                 avs_read;
   logic                 avs_write;
   logic [ICIR_DW-1:0]   avs_writedata;
   logic [ICIR_BEW-1:0]  avs_byteenable;
   logic [ICIR_DW-1:0]   avs_readdata;
   logic                 avs_waitrequest;
   logic [ICIR_TX_N-1:0] tx_context_int;
   logic [ICIR_RX_N-1:0] rx_channel_int;
   logic                 summary_transmit_event;
   logic                 summary_receive_event;
   logic                 irq;
   logic [ICIR_TX_N-1:0] tx_ev;
   logic [ICIR_TX_N-1:0] tx_msk;
   logic [ICIR_RX_N-1:0] rx_ev;
   logic [ICIR_RX_N-1:0] rx_msk;
   logic [ICIR_DW-1:0]   rd;
   int                   err_count = 0;
   int                   total_checks = 0;
   int                   cycles = 0;

   icir_regs u_dut (.clk(clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .tx_context_int(tx_context_int), .rx_channel_int(rx_channel_int),
      .summary_transmit_event(summary_transmit_event),
      .summary_receive_event(summary_receive_event), .irq(irq));

   // Free-running 100 MHz clock.
   initial clk = 1'b0;
   always #5 clk = ~clk;

   // Cuts a hang short; the whole run needs only about a thousand cycles.
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_count++;
         $display("unexpected at %0t: run timed out", $time);
         results();
      end
   end

   // Prints the counts and the verdict, then ends the run.
   task automatic results();
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // Keeps only the enabled byte lanes; disabled lanes write as zero.
   function automatic logic [ICIR_DW-1:0] lanes(input logic [ICIR_DW-1:0] d,
                                                input logic [ICIR_BEW-1:0] be);
      logic [ICIR_DW-1:0] m;
      for (int i = 0; i < 4; i++) begin
         m[i*8 +: 8] = be[i] ? d[i*8 +: 8] : 8'h00;
      end
      return m;
   endfunction

   // Expected read data of the bench's own register model.
   function automatic logic [ICIR_DW-1:0] expect_rd(input logic [ICIR_AW-1:0] a);
      case (a)
         ICIR_TX_EV_SET: return {24'h000000, tx_ev};
         ICIR_TX_EV_CLR: return {24'h000000, tx_ev & tx_msk};
         ICIR_TX_MSK_SET, ICIR_TX_MSK_CLR: return {24'h000000, tx_msk};
         ICIR_RX_EV_SET: return {28'h0000000, rx_ev};
         ICIR_RX_EV_CLR: return {28'h0000000, rx_ev & rx_msk};
         ICIR_RX_MSK_SET, ICIR_RX_MSK_CLR: return {28'h0000000, rx_msk};
         default: return 32'h0000_0000;
      endcase
   endfunction

   // Applies a completed write to the model; only ones set or clear.
   task automatic model_wr(input logic [ICIR_AW-1:0] a, input logic [ICIR_DW-1:0] d);
      case (a)
         ICIR_TX_EV_SET: tx_ev = tx_ev | d[7:0];
         ICIR_TX_EV_CLR: tx_ev = tx_ev & ~d[7:0];
         ICIR_TX_MSK_SET: tx_msk = tx_msk | d[7:0];
         ICIR_TX_MSK_CLR: tx_msk = tx_msk & ~d[7:0];
         ICIR_RX_EV_SET: rx_ev = rx_ev | d[3:0];
         ICIR_RX_EV_CLR: rx_ev = rx_ev & ~d[3:0];
         ICIR_RX_MSK_SET: rx_msk = rx_msk | d[3:0];
         ICIR_RX_MSK_CLR: rx_msk = rx_msk & ~d[3:0];
         default: ;
      endcase
   endtask

   // One Avalon-MM access; the request is held until waitrequest is sampled low.
   task automatic bus(input logic wr, input logic [ICIR_AW-1:0] a, input logic [ICIR_DW-1:0] d,
                      input logic [ICIR_BEW-1:0] be, output logic [ICIR_DW-1:0] q);
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      avs_read <= ~wr;
      avs_write <= wr;
      do @(posedge clk);
      while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (wr)
         model_wr(a, lanes(d, be));
   endtask

   // Reads one register and compares it with the model.
   task automatic chk_reg(input logic [ICIR_AW-1:0] a);
      bus(1'b0, a, 32'h0000_0000, 4'hf, rd);
      `CHK(rd, expect_rd(a))
   endtask

   // Compares both summary outputs after they have had time to follow.
   task automatic chk_sum();
      repeat (2) @(posedge clk);
      `CHK(summary_transmit_event, |(tx_ev & tx_msk))
      `CHK(summary_receive_event, |(rx_ev & rx_msk))
   endtask

   // One-cycle completion pulses; the inputs then rest low so that edges stay distinct.
   task automatic pulse(input logic [ICIR_TX_N-1:0] t, input logic [ICIR_RX_N-1:0] r);
      @(posedge clk);
      tx_context_int <= t;
      rx_channel_int <= r;
      @(posedge clk);
      tx_context_int <= '0;
      rx_channel_int <= '0;
      tx_ev = tx_ev | t;
      rx_ev = rx_ev | r;
      repeat (3) @(posedge clk);
   endtask

   // Main sequence: reset, directed corners, random traffic, interrupt path.
   initial begin
      nrst = 1'b0;
      avs_address = '0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = '0;
      avs_byteenable = 4'hf;
      tx_context_int = '0;
      rx_channel_int = '0;
      tx_ev = '0;
      tx_msk = '0;
      rx_ev = '0;
      rx_msk = '0;
      void'($urandom(45));
      repeat (6) @(posedge clk);
      `CHK(avs_waitrequest, 1'b1)
      `CHK(irq, 1'b0)
      nrst <= 1'b1;
      foreach (ADDR_TAB[i]) chk_reg(ADDR_TAB[i]);
      bus(1'b1, 8'h50, 32'hffff_ffff, 4'hf, rd);
      chk_reg(8'h50);
      // Reserved bits ignore ones; zeros and set writes never clear.
      bus(1'b1, ICIR_TX_EV_SET, 32'hffff_ff5a, 4'hf, rd);
      chk_reg(ICIR_TX_EV_SET);
      bus(1'b1, ICIR_TX_EV_CLR, 32'h0000_0000, 4'hf, rd);
      bus(1'b1, ICIR_TX_EV_SET, 32'h0000_0000, 4'hf, rd);
      chk_reg(ICIR_TX_EV_SET);
      bus(1'b1, ICIR_TX_MSK_SET, 32'hffff_ff0f, 4'hf, rd);
      chk_reg(ICIR_TX_MSK_CLR);
      chk_reg(ICIR_TX_EV_CLR);
      chk_sum();
      bus(1'b1, ICIR_RX_EV_SET, 32'hffff_fff6, 4'hf, rd);
      chk_reg(ICIR_RX_EV_SET);
      bus(1'b1, ICIR_RX_MSK_SET, 32'h0000_0003, 4'hf, rd);
      chk_reg(ICIR_RX_EV_CLR);
      chk_sum();
      // A level held high yields one event only; a clear then sticks.
      bus(1'b1, ICIR_TX_EV_CLR, 32'h0000_00ff, 4'hf, rd);
      bus(1'b1, ICIR_RX_EV_CLR, 32'h0000_000f, 4'hf, rd);
      @(posedge clk);
      tx_context_int <= 8'h04;
      rx_channel_int <= 4'h2;
      repeat (3) @(posedge clk);
      tx_ev = 8'h04;
      rx_ev = 4'h2;
      chk_reg(ICIR_TX_EV_SET);
      bus(1'b1, ICIR_TX_EV_CLR, 32'h0000_0004, 4'hf, rd);
      bus(1'b1, ICIR_RX_EV_CLR, 32'h0000_0002, 4'hf, rd);
      chk_reg(ICIR_TX_EV_SET);
      chk_reg(ICIR_RX_EV_SET);
      @(posedge clk);
      tx_context_int <= '0;
      rx_channel_int <= '0;
      repeat (2) @(posedge clk);
      // Random writes, lane masks and completion pulses against the model.
      repeat (80) begin
         if ($urandom_range(0, 2) == 0)
            pulse(8'($urandom_range(0, 255)), 4'($urandom_range(0, 15)));
         bus(1'b1, ADDR_TAB[$urandom_range(0, 7)], $urandom, 4'($urandom_range(0, 15)), rd);
         chk_reg(ADDR_TAB[$urandom_range(0, 7)]);
         chk_sum();
      end
      // Interrupt path: global enable, interrupt mask, read-clear status.
      bus(1'b1, ICIR_TX_EV_CLR, 32'h0000_00ff, 4'hf, rd);
      bus(1'b1, ICIR_RX_EV_CLR, 32'h0000_000f, 4'hf, rd);
      bus(1'b1, ICIR_TX_MSK_SET, 32'h0000_0001, 4'hf, rd);
      bus(1'b1, ICIR_IRQ_MASK, 32'h0000_00c0, 4'hf, rd);
      bus(1'b1, ICIR_CTRL, 32'h0000_00c0, 4'hf, rd);
      pulse(8'h01, 4'h0);
      repeat (4) @(posedge clk);
      `CHK(summary_transmit_event, 1'b1)
      `CHK(irq, 1'b0)
      bus(1'b1, ICIR_CTRL, 32'h8000_00c0, 4'hf, rd);
      repeat (4) @(posedge clk);
      `CHK(irq, 1'b1)
      chk_reg(ICIR_TX_EV_SET);
      bus(1'b1, ICIR_IRQ_MASK, 32'h0000_0000, 4'hf, rd);
      repeat (4) @(posedge clk);
      `CHK(irq, 1'b0)
      bus(1'b1, ICIR_IRQ_MASK, 32'h0000_00c0, 4'hf, rd);
      bus(1'b1, ICIR_TX_EV_CLR, 32'h0000_0001, 4'hf, rd);
      repeat (4) @(posedge clk);
      bus(1'b0, ICIR_IRQ_STAT, 32'h0000_0000, 4'hf, rd);
      `CHK(rd, 32'h0000_0040)
      bus(1'b0, ICIR_IRQ_STAT, 32'h0000_0000, 4'hf, rd);
      `CHK(rd, 32'h0000_0000)
      repeat (4) @(posedge clk);
      `CHK(irq, 1'b0)
      results();
   end
endmodule
`default_nettype wire
